// ===== src/ufc_regs.vh
`ifndef UFC_REGS_VH
`define UFC_REGS_VH
`define UFC_BLOCK_COUNT    16'h0077
`define UFC_BLOCK_SIZE     16'h0200
`define UFC_CLUSTER_ID     16'h0023
`define UFC_ENDPOINT       8'he6
`define UFC_HDR_LEN        4'h8
`define UFC_OFF_CMD        3'h0
`define UFC_OFF_OPT        3'h1
`define UFC_OFF_BLK_HI     3'h2
`define UFC_OFF_BLK_LO     3'h3
`define UFC_OFF_IDX_HI     3'h4
`define UFC_OFF_IDX_LO     3'h5
`define UFC_OFF_LEN_HI     3'h6
`define UFC_OFF_LEN_LO     3'h7
`define UFC_CMD_GEOM_Q     8'h00
`define UFC_CMD_GEOM_R     8'h80
`define UFC_STAT_FAIL_BIT  0
`endif

// ===== src/ufc_hdr_parse.v
`timescale 1ns/1ps
`default_nettype none
`include "ufc_regs.vh"
// ----------------------------------------
// Request header capture
// ----------------------------------------
module ufc_hdr_parse (
    input  wire        clk,
    input  wire        rst,
    input  wire        in_valid,
    input  wire [7:0]  in_data,
    input  wire        in_last,
    output reg  [7:0]  cmd_ff,
    output reg  [7:0]  opt_ff,
    output reg  [15:0] blk_ff,
    output reg  [15:0] idx_ff,
    output reg  [15:0] len_ff,
    output reg         done_ff,
    output reg         short_ff
);
    reg [3:0] cnt_ff;
    always @(posedge clk) begin
        if (rst) begin
            cnt_ff   <= 4'h0;
            cmd_ff   <= 8'h00;
            opt_ff   <= 8'h00;
            blk_ff   <= 16'h0000;
            idx_ff   <= 16'h0000;
            len_ff   <= 16'h0000;
            done_ff  <= 1'b0;
            short_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (in_valid) begin
                if (cnt_ff < `UFC_HDR_LEN) begin
                    case (cnt_ff[2:0])
                        `UFC_OFF_CMD:    cmd_ff        <= in_data;
                        `UFC_OFF_OPT:    opt_ff        <= in_data;
                        `UFC_OFF_BLK_HI: blk_ff[15:8]  <= in_data;
                        `UFC_OFF_BLK_LO: blk_ff[7:0]   <= in_data;
                        `UFC_OFF_IDX_HI: idx_ff[15:8]  <= in_data;
                        `UFC_OFF_IDX_LO: idx_ff[7:0]   <= in_data;
                        `UFC_OFF_LEN_HI: len_ff[15:8]  <= in_data;
                        default:         len_ff[7:0]   <= in_data;
                    endcase
                    cnt_ff <= cnt_ff + 4'h1;
                end
                if (in_last) begin
                    cnt_ff   <= 4'h0;
                    done_ff  <= 1'b1;
                    short_ff <= (cnt_ff < (`UFC_HDR_LEN - 4'h1));
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/ufc_top.v
// Notes on behaviour
// - Store holds 119 blocks of 512 bytes each.
// - Commands arrive on cluster 0x23, endpoint 0xe6.
// - Header: command, options, block, offset, length; data from byte 8.
// - Two-byte fields go most significant byte first.
// - Reply only to unicast requests, to requester's source endpoint.
// - Reply shown as explicit receive frame in API mode only, when source endpoint 0xe6 or explicit mode.
// - Reply gives response code 0x80 at 0, status at 1, other fields in place.
// - Length counts data bytes, or requested bytes for a read.
// - Command 0x00 is geometry query, answered with 0x80.
// - Reply gives block count in block field, zero length, no data.
// - Reply gives block size in offset field.
// - Status bit 0 set on failure, clear on success, rest reserved.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_regs.vh"
module ufc_top #(
    parameter [15:0] BLOCK_COUNT = `UFC_BLOCK_COUNT,
    parameter [15:0] BLOCK_SIZE  = `UFC_BLOCK_SIZE
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        req_valid,
    input  wire [7:0]  req_data,
    input  wire        req_last,
    input  wire [15:0] req_cluster,
    input  wire [7:0]  req_dst_ep,
    input  wire [7:0]  req_src_ep,
    input  wire        req_broadcast,
    input  wire        api_mode,
    input  wire        explicit_mode,
    input  wire        rsp_ready,
    output reg         rsp_valid_ff,
    output reg  [7:0]  rsp_data_ff,
    output reg         rsp_last_ff,
    output reg  [7:0]  rsp_dst_ep_ff,
    output reg         rsp_explicit_ff,
    output reg         busy_ff,
    output reg         drop_ff
);
    // ----------------------------------------
    // Frame filter and header capture
    // ----------------------------------------
    wire        hit;
    wire [7:0]  h_cmd;
    wire [7:0]  h_opt;
    wire [15:0] h_blk;
    wire [15:0] h_idx;
    wire [15:0] h_len;
    wire        h_done;
    wire        h_short;
    reg         bcast_ff;
    reg  [7:0]  src_ff;
    reg         expl_ff;
    reg  [7:0]  nxt_byte;
    wire        ctx_expl;
    wire        bad_req;

    // Cluster and endpoint filter for one payload byte
    function frame_hit;
        input        valid;
        input        busy;
        input [15:0] cluster;
        input [7:0]  dst_ep;
        begin
            frame_hit = valid && !busy && (cluster == `UFC_CLUSTER_ID) && (dst_ep == `UFC_ENDPOINT);
        end
    endfunction

    // Explicit indication wanted for a reply to this requester
    function want_explicit;
        input       api_on;
        input       expl_on;
        input [7:0] src_ep;
        begin
            want_explicit = api_on && ((src_ep == `UFC_ENDPOINT) || expl_on);
        end
    endfunction

    assign hit      = frame_hit(req_valid, busy_ff, req_cluster, req_dst_ep);
    assign ctx_expl = want_explicit(api_mode, explicit_mode, req_src_ep);
    assign bad_req  = h_short || (h_cmd != `UFC_CMD_GEOM_Q);

    ufc_hdr_parse u_parse (
        .clk      (clk),
        .rst      (rst),
        .in_valid (hit),
        .in_data  (req_data),
        .in_last  (req_last),
        .cmd_ff   (h_cmd),
        .opt_ff   (h_opt),
        .blk_ff   (h_blk),
        .idx_ff   (h_idx),
        .len_ff   (h_len),
        .done_ff  (h_done),
        .short_ff (h_short)
    );

    // ----------------------------------------
    // Requester context, kept from the last accepted byte
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            bcast_ff <= 1'b0;
            src_ff   <= 8'h00;
            expl_ff  <= 1'b0;
        end else if (hit) begin
            bcast_ff <= req_broadcast;
            src_ff   <= req_src_ep;
            expl_ff  <= ctx_expl;
        end
    end

    // ----------------------------------------
    // Reply sequencer
    // ----------------------------------------
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_SEND = 2'b01;
    localparam [1:0] ST_HOLD = 2'b10;
    reg  [1:0]  state_ff;
    reg  [2:0]  pos_ff;
    reg  [7:0]  status_ff;
    wire        take_query;

    function [7:0] geom_byte;
        input [2:0] pos;
        input [7:0] status;
        begin
            case (pos)
                `UFC_OFF_CMD:    geom_byte = `UFC_CMD_GEOM_R;
                `UFC_OFF_OPT:    geom_byte = status;
                `UFC_OFF_BLK_HI: geom_byte = BLOCK_COUNT[15:8];
                `UFC_OFF_BLK_LO: geom_byte = BLOCK_COUNT[7:0];
                `UFC_OFF_IDX_HI: geom_byte = BLOCK_SIZE[15:8];
                `UFC_OFF_IDX_LO: geom_byte = BLOCK_SIZE[7:0];
                default:         geom_byte = 8'h00;
            endcase
        end
    endfunction

    // Failure flag for a query that carries nonzero fields
    function [7:0] query_status;
        input [7:0]  opt;
        input [15:0] blk;
        input [15:0] idx;
        input [15:0] len;
        begin
            query_status = 8'h00;
            query_status[`UFC_STAT_FAIL_BIT] = (opt != 8'h00) || (blk != 16'h0000)
                                               || (idx != 16'h0000) || (len != 16'h0000);
        end
    endfunction

    assign take_query = (state_ff == ST_IDLE) && h_done && !bad_req && !bcast_ff;

    always @* begin
        nxt_byte = geom_byte(pos_ff, status_ff);
    end

    always @(posedge clk) begin
        if (rst) begin
            state_ff     <= ST_IDLE;
            pos_ff       <= 3'h0;
            status_ff    <= 8'h00;
            busy_ff      <= 1'b0;
            drop_ff      <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff  <= 8'h00;
            rsp_last_ff  <= 1'b0;
        end else begin
            drop_ff <= (state_ff == ST_IDLE) && h_done && bad_req;
            case (state_ff)
                ST_IDLE: begin
                    if (take_query) begin
                        // Nonzero fields still answered, flagged as error
                        status_ff <= query_status(h_opt, h_blk, h_idx, h_len);
                        pos_ff    <= 3'h0;
                        busy_ff   <= 1'b1;
                        state_ff  <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (!rsp_valid_ff || rsp_ready) begin
                        rsp_valid_ff <= 1'b1;
                        rsp_data_ff  <= nxt_byte;
                        rsp_last_ff  <= (pos_ff == `UFC_OFF_LEN_LO);
                        pos_ff       <= pos_ff + 3'h1;
                        if (pos_ff == `UFC_OFF_LEN_LO) begin
                            state_ff <= ST_HOLD;
                        end
                    end
                end
                ST_HOLD: begin
                    if (rsp_ready) begin
                        rsp_valid_ff <= 1'b0;
                        rsp_last_ff  <= 1'b0;
                        busy_ff      <= 1'b0;
                        state_ff     <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Reply addressing, held until the next reply
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rsp_dst_ep_ff   <= 8'h00;
            rsp_explicit_ff <= 1'b0;
        end else if (take_query) begin
            rsp_dst_ep_ff   <= src_ff;
            rsp_explicit_ff <= expl_ff;
        end
    end
endmodule
`default_nettype wire

// ===== dv/ufc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire logic        req_last,
    input wire logic [15:0] req_cluster,
    input wire logic [7:0]  req_dst_ep,
    input wire logic [7:0]  req_src_ep,
    input wire logic        req_broadcast,
    input wire logic        api_mode,
    input wire logic        explicit_mode,
    input wire logic        rsp_ready,
    input wire logic        rsp_valid_ff,
    input wire logic [7:0]  rsp_data_ff,
    input wire logic        rsp_last_ff,
    input wire logic [7:0]  rsp_dst_ep_ff,
    input wire logic        rsp_explicit_ff,
    input wire logic        busy_ff,
    input wire logic        drop_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [2:0] beat_ff;
    logic       fail_ff;
    wire        fin = req_valid && req_last && !busy_ff && req_cluster == 16'h0023 && req_dst_ep == 8'he6;
    wire [47:0] geo = 48'h0077_0200_0000;
    // Reply byte position and latched failure bit
    always_ff @(posedge clk) begin
        beat_ff <= rst ? 3'h0 : beat_ff + 3'(rsp_valid_ff && rsp_ready);
        fail_ff <= (rsp_valid_ff && beat_ff == 3'h1) ? rsp_data_ff[0] : fail_ff;
    end
    a_reply_or_drop: assert property (fin && !req_broadcast |-> (##2 drop_ff) or (##3 $rose(rsp_valid_ff)))
        else $error("request neither answered nor dropped");
    a_busy_cover: assert property (rsp_valid_ff |-> busy_ff)
        else $error("reply byte shown while not busy");
    a_bcast_silent: assert property (fin && req_broadcast |=> (!drop_ff && !rsp_valid_ff)[*5])
        else $error("broadcast request answered");
    a_reply_code: assert property ($rose(rsp_valid_ff) |-> rsp_data_ff == 8'h80 && beat_ff == 3'h0)
        else $error("reply code wrong");
    a_geom_fields: assert property (rsp_valid_ff && beat_ff > 3'h1 && !fail_ff |-> rsp_data_ff == geo[8*(7-beat_ff) +: 8])
        else $error("geometry field byte wrong");
    a_status_rsvd: assert property (rsp_valid_ff && beat_ff == 3'h1 |-> rsp_data_ff[7:1] == 7'h00)
        else $error("reserved status bits set");
    a_byte_hold: assert property (rsp_valid_ff && !rsp_ready |=> rsp_valid_ff && $stable(rsp_data_ff))
        else $error("reply byte not held");
    a_last_beat: assert property (rsp_valid_ff |-> rsp_last_ff == (beat_ff == 3'h7))
        else $error("reply length wrong");
    a_reply_ep: assert property (rsp_valid_ff |-> rsp_dst_ep_ff == req_src_ep)
        else $error("reply endpoint wrong");
    a_explicit_ind: assert property (rsp_valid_ff |-> rsp_explicit_ff == (api_mode && (req_src_ep == 8'he6 || explicit_mode)))
        else $error("explicit indication wrong");
    c_reply: cover property ($rose(rsp_valid_ff));
    c_drop: cover property (drop_ff);
    c_stall: cover property (rsp_valid_ff && !rsp_ready);
endmodule
bind ufc_top ufc_asserts u_chk (.*);
`default_nettype wire

// ===== dv/ufc_rsp_sink.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_rsp_sink (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        rsp_valid_ff,
    input  wire logic [7:0]  rsp_data_ff,
    input  wire logic        rsp_last_ff,
    output var  logic        ready_ff,
    output var  logic [63:0] frame_ff,
    output var  logic [7:0]  count_ff
);
    logic [1:0] tick_ff;
    // Consumer that can stall three cycles in four
    always_ff @(posedge clk) begin
        tick_ff <= rst ? 2'h0 : tick_ff + 2'h1;
        ready_ff <= !rst && (!slow || tick_ff == 2'h3);
        if (rst) begin
            frame_ff <= 64'h0;
            count_ff <= 8'h0;
        end else if (rsp_valid_ff && ready_ff) begin
            frame_ff <= {frame_ff[55:0], rsp_data_ff};
            count_ff <= count_ff + 8'(rsp_last_ff);
        end
    end
endmodule
`default_nettype wire

// ===== dv/tb_user_flash_command_handler.sv
`timescale 1ns/1ps
`default_nettype none
module tb_user_flash_command_handler;
    logic        clk = 1'h0, rst = 1'h1, req_valid = 1'h0, req_last = 1'h0, req_broadcast = 1'h0;
    logic        api_mode = 1'h1, explicit_mode = 1'h0, slow = 1'h0;
    logic [7:0]  req_data = 8'h0, req_dst_ep = 8'he6, req_src_ep = 8'he6, ndrop = 8'h0;
    logic [15:0] req_cluster = 16'h0023;
    logic        rsp_ready, rsp_valid_ff, rsp_last_ff, rsp_explicit_ff, busy_ff, drop_ff;
    logic [7:0]  rsp_data_ff, rsp_dst_ep_ff, nfr;
    logic [63:0] frame;
    int          failures = 0, check_count = 0, cyc = 0;
    always #2.5 clk = ~clk;
    ufc_top dut (.*);
    ufc_rsp_sink sink (.clk, .rst, .slow, .rsp_valid_ff, .rsp_data_ff, .rsp_last_ff,
                       .ready_ff(rsp_ready), .frame_ff(frame), .count_ff(nfr));
    always @(posedge clk) begin
        ndrop <= ndrop + 8'(drop_ff === 1'h1);
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            give_verdict;
        end
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Header bytes most significant first, no data bytes
    task send(input logic [63:0] hdr, input int n, input logic bc, input logic [15:0] cl);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            req_broadcast <= bc;
            req_cluster <= cl;
            req_valid <= 1'h1;
            req_data <= hdr[63-8*i -: 8];
            req_last <= (i == n - 1);
        end
        @(posedge clk);
        req_valid <= 1'h0;
        req_last <= 1'h0;
        repeat (6) @(posedge clk);
        while (busy_ff !== 1'h0) @(posedge clk);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        send(64'h0, 8, 1'h0, 16'h0023);
        check(frame, 64'h8000_0077_0200_0000);
        check({63'h0, rsp_explicit_ff}, 64'h1);
        slow <= 1'h1;
        req_src_ep <= 8'h10;
        send(64'h0000_0001_0000_0000, 8, 1'h0, 16'h0023);
        check({48'h0, frame[63:48]}, 64'h8001);
        check({56'h0, rsp_dst_ep_ff}, 64'h10);
        check({63'h0, rsp_explicit_ff}, 64'h0);
        send(64'h0, 8, 1'h1, 16'h0023);
        check({nfr, ndrop}, 16'h0200);
        send(64'h0100_0000_0000_0000, 8, 1'h0, 16'h0023);
        check({nfr, ndrop}, 16'h0201);
        send(64'h0, 4, 1'h0, 16'h0023);
        check({nfr, ndrop}, 16'h0202);
        send(64'h0, 8, 1'h0, 16'h0024);
        check({nfr, ndrop}, 16'h0202);
        explicit_mode <= 1'h1;
        send(64'h0, 8, 1'h0, 16'h0023);
        check(frame, 64'h8000_0077_0200_0000);
        check({63'h0, rsp_explicit_ff}, 64'h1);
        api_mode <= 1'h0;
        send(64'h0, 8, 1'h0, 16'h0023);
        check(frame, 64'h8000_0077_0200_0000);
        check({63'h0, rsp_explicit_ff}, 64'h0);
        check({nfr, ndrop}, 16'h0402);
        give_verdict;
    end
endmodule
`default_nettype wire
